/* File: common/i2s_defines.svh */
// Register offsets, field positions, reset values and mode codes of the I2C slave port
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers
`ifndef I2S_DEFINES_SVH
`define I2S_DEFINES_SVH
`define I2S_OFS_CTRL 8'h00
`define I2S_OFS_STAT 8'h04
`define I2S_OFS_ADDR 8'h08
`define I2S_OFS_BUF 8'h0c
`define I2S_OFS_IRQ 8'h10
`define I2S_CTRL_RST 8'h00
`define I2S_STAT_RST 8'h00
`define I2S_MASK_RST 8'hff
`define I2S_ADDR_RST 8'h00
`define I2S_B_COLL 7
`define I2S_B_OV 6
`define I2S_B_EN 5
`define I2S_B_CKR 4
`define I2S_B_SLEW 7
`define I2S_B_EDGE 6
`define I2S_M_S7 4'h6
`define I2S_M_S10 4'h7
`define I2S_M_MASK 4'h9
`define I2S_M_FWM 4'hb
`define I2S_M_S7I 4'he
`define I2S_M_S10I 4'hf
`define I2S_TEN_HDR 5'h1e
`endif

/* File: common/i2s_pkg.sv */
// Types shared by the I2C slave port modules
// Assumes i2s_defines.svh holds all numeric constants
`default_nettype none
package i2s_pkg;
   typedef enum logic [2:0] {st_idle, st_addr, st_addr_lo, st_rx, st_tx, st_skip} i2s_state_t;
endpackage : i2s_pkg
`default_nettype wire

/* File: rtl/i2s_sync.sv */
// Two-flop synchroniser for the bus pins
// Assumes inputs are asynchronous to pclk
`timescale 1ns/100ps
`default_nettype none
module i2s_sync #(parameter int W = 2) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '1;
         q <= '1;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : i2s_sync
`default_nettype wire

/* File: rtl/i2s_match.sv */
// Masked address comparator
// Assumes all inputs come from pclk registers
`timescale 1ns/100ps
`default_nettype none
module i2s_match (
   // Operands
   input wire logic [7:0] rx,
   input wire logic [7:0] own,
   input wire logic [7:0] mask,
   input wire logic use_bit0,
   // Result
   output logic hit
);
   logic [7:0] care;
   assign care = {mask[7:1], mask[0] & use_bit0};
   assign hit = &(~(rx ^ own) | ~care);
endmodule : i2s_match
`default_nettype wire

/* File: rtl/i2s_slave.sv */
// I2C slave serial port with APB register access
// Assumes SCL/SDA are open-drain pins resolved outside; pclk 20 MHz
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "i2s_defines.svh"
module i2s_slave import i2s_pkg::*; (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // I2C pins
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_n,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // Pin and system control
   output logic port_owns_pins,
   output logic slew_limit_en,
   output logic irq,
   output logic wake_req
);
   //////////////////////////////////////////////////////////////////////////////
   logic [7:0] port_control, port_status_sw, address_mask, own_address, shift_buffer, tx_shift, rx_shift;
   logic write_collision, receive_overflow, clock_release, port_irq_flag, port_irq_enable;
   logic data_not_address, stop_bit, start_bit, read_not_write, address_update_needed, buffer_full;
   logic [1:0] pins_s;
   logic scl_s, sda_s, scl_d, sda_d, scl_rise, scl_fall, start_det, stop_det;
   logic [3:0] cnt;
   i2s_state_t state;
   logic ack_drive, master_nack, ten_ok, arm, scl_hold, hit;
   logic port_enable, slave_on, ten, ss_irq, mask_sel, use_bit0;
   logic setup, acc, wr, rd, unmapped, fall8, fall9, shifting;
   logic ev_load, ev_ov, ev_rdreq, ev_upd, ev_flag, ev_dna, ev_ada;
   //////////////////////////////////////////////////////////////////////////////
   // Mode decode
   assign port_enable = port_control[`I2S_B_EN];
   assign slave_on = port_enable && (port_control[3:0] == `I2S_M_S7 || port_control[3:0] == `I2S_M_S10 ||
      port_control[3:0] == `I2S_M_S7I || port_control[3:0] == `I2S_M_S10I);
   assign ten = slave_on && port_control[0];
   assign ss_irq = port_enable && (port_control[3:0] == `I2S_M_S7I || port_control[3:0] == `I2S_M_S10I ||
      port_control[3:0] == `I2S_M_FWM);
   assign mask_sel = port_control[3:0] == `I2S_M_MASK;
   assign port_owns_pins = port_enable;
   assign slew_limit_en = !port_status_sw[`I2S_B_SLEW];
   //////////////////////////////////////////////////////////////////////////////
   // Pin sampling and bus conditions
   i2s_sync #(.W(2)) u_sync (.pclk(pclk), .presetn(presetn), .d({scl_in, sda_in}), .q(pins_s));
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start_det = port_enable && scl_s && scl_d && sda_d && !sda_s;
   assign stop_det = port_enable && scl_s && scl_d && !sda_d && sda_s;
   assign fall8 = scl_fall && cnt == 4'd8;
   assign fall9 = scl_fall && cnt == 4'd9;
   assign shifting = state == st_tx && cnt != 4'd0 && cnt < 4'd8;
   //////////////////////////////////////////////////////////////////////////////
   // Address match
   assign use_bit0 = ten && state == st_addr_lo;
   i2s_match u_match (.rx(rx_shift), .own(own_address), .mask(address_mask), .use_bit0(use_bit0), .hit(hit));
   //////////////////////////////////////////////////////////////////////////////
   // Byte events decided at the 8th falling edge; flag event at the 9th or at start/stop
   always_comb begin
      ev_load = 1'b0;
      ev_ov = 1'b0;
      ev_rdreq = 1'b0;
      ev_upd = 1'b0;
      ev_ada = 1'b0;
      ev_dna = 1'b0;
      if (fall8) begin
         unique case (state)
            st_addr: begin
               if (ten && rx_shift[7:3] == `I2S_TEN_HDR) begin
                  if (hit && !rx_shift[0]) begin
                     ev_load = 1'b1;
                     ev_upd = 1'b1;
                     ev_ada = 1'b1;
                  end else if (hit && ten_ok) begin
                     ev_rdreq = 1'b1;
                     ev_ada = 1'b1;
                  end
               end else if (!ten && hit) begin
                  ev_ada = 1'b1;
                  ev_rdreq = rx_shift[0];
                  ev_load = !rx_shift[0] && !buffer_full;
                  ev_ov = !rx_shift[0] && buffer_full;
               end
            end
            st_addr_lo: begin
               ev_load = hit;
               ev_upd = hit;
               ev_ada = hit;
            end
            st_rx: begin
               ev_dna = 1'b1;
               ev_load = !buffer_full;
               ev_ov = buffer_full;
            end
            st_tx: ev_dna = 1'b1;
            default: ;
         endcase
      end
   end
   assign ev_flag = (fall9 && (ack_drive || state == st_tx)) || (ss_irq && (start_det || stop_det));
   //////////////////////////////////////////////////////////////////////////////
   // Link state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_idle;
         cnt <= 4'd0;
         rx_shift <= 8'h00;
         ack_drive <= 1'b0;
         master_nack <= 1'b0;
         ten_ok <= 1'b0;
      end else if (!slave_on || stop_det) begin
         state <= st_idle;
         cnt <= 4'd0;
         ack_drive <= 1'b0;
         ten_ok <= 1'b0;
      end else if (start_det) begin
         state <= st_addr;
         cnt <= 4'd0;
         ack_drive <= 1'b0;
      end else if (state != st_idle) begin
         if (scl_rise && cnt < 4'd8) begin
            rx_shift <= {rx_shift[6:0], sda_s};
            cnt <= cnt + 4'd1;
         end else if (scl_rise) begin
            master_nack <= sda_s;
            cnt <= 4'd9;
         end
         if (fall8) begin
            ack_drive <= ev_ada || (state == st_rx && !buffer_full);
            if (state == st_addr || state == st_addr_lo) begin
               if (ev_rdreq) state <= st_tx;
               else if (ev_upd && state == st_addr) state <= st_addr_lo;
               else if (ev_ada) state <= st_rx;
               else state <= st_skip;
            end
            if (state == st_addr_lo && hit) ten_ok <= 1'b1;
         end
         if (fall9) begin
            cnt <= 4'd0;
            ack_drive <= 1'b0;
            if (state == st_tx && !ack_drive && master_nack) state <= st_skip;
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Clock stretching and pin drive
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm <= 1'b0;
      end else if (!slave_on || stop_det) begin
         arm <= 1'b0;
      end else if (fall9 && (address_update_needed || (state == st_tx && !(master_nack && !ack_drive)))) begin
         arm <= 1'b1;
      end else if (clock_release && !address_update_needed) begin
         arm <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_hold <= 1'b0;
      end else begin
         scl_hold <= arm && (scl_hold || !scl_s);
      end
   end
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe_n = !(port_enable && scl_hold);
   assign sda_oe_n = !(port_enable && (ack_drive || (state == st_tx && !tx_shift[7])));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_shift <= 8'hff;
      end else if (wr && paddr == `I2S_OFS_BUF && !shifting) begin
         tx_shift <= pwdata[7:0];
      end else if (scl_fall && state == st_tx && cnt != 4'd0 && cnt < 4'd9) begin
         tx_shift <= {tx_shift[6:0], 1'b1};
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // APB decode
   assign setup = psel && !penable;
   assign acc = psel && penable;
   assign wr = acc && pwrite && !unmapped;
   assign rd = acc && !pwrite && !unmapped;
   assign unmapped = paddr != `I2S_OFS_CTRL && paddr != `I2S_OFS_STAT && paddr != `I2S_OFS_ADDR &&
      paddr != `I2S_OFS_BUF && paddr != `I2S_OFS_IRQ;
   assign pready = 1'b1;
   assign pslverr = acc && unmapped;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         unique case (paddr)
            `I2S_OFS_CTRL: prdata <= {24'h000000, port_control};
            `I2S_OFS_STAT: prdata <= {24'h000000, port_status_sw[7:6], data_not_address, stop_bit, start_bit,
               read_not_write, address_update_needed, buffer_full};
            `I2S_OFS_ADDR: prdata <= {24'h000000, mask_sel ? address_mask : own_address};
            `I2S_OFS_BUF: prdata <= {24'h000000, shift_buffer};
            `I2S_OFS_IRQ: prdata <= {30'h00000000, port_irq_enable, port_irq_flag};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_control <= `I2S_CTRL_RST;
      end else begin
         if (wr && paddr == `I2S_OFS_CTRL) port_control <= pwdata[7:0];
         if (wr && paddr == `I2S_OFS_CTRL && pwdata[`I2S_B_COLL] == 1'b0) port_control[`I2S_B_COLL] <= 1'b0;
         if (wr && paddr == `I2S_OFS_BUF && shifting) port_control[`I2S_B_COLL] <= 1'b1;
         if (ev_ov) port_control[`I2S_B_OV] <= 1'b1;
         if (ev_rdreq) port_control[`I2S_B_CKR] <= 1'b0;
      end
   end
   assign write_collision = port_control[`I2S_B_COLL];
   assign receive_overflow = port_control[`I2S_B_OV];
   assign clock_release = port_control[`I2S_B_CKR];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_status_sw <= `I2S_STAT_RST;
      end else if (wr && paddr == `I2S_OFS_STAT) begin
         port_status_sw <= {pwdata[7:6], 6'h00};
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         address_mask <= `I2S_MASK_RST;
         own_address <= `I2S_ADDR_RST;
      end else if (wr && paddr == `I2S_OFS_ADDR && mask_sel) begin
         address_mask <= pwdata[7:0];
      end else if (wr && paddr == `I2S_OFS_ADDR) begin
         own_address <= pwdata[7:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_irq_flag <= 1'b0;
         port_irq_enable <= 1'b0;
      end else begin
         if (wr && paddr == `I2S_OFS_IRQ) port_irq_enable <= pwdata[1];
         port_irq_flag <= ev_flag || ((wr && paddr == `I2S_OFS_IRQ) ? pwdata[0] : port_irq_flag);
      end
   end
   assign irq = port_irq_flag && port_irq_enable;
   assign wake_req = irq;
   //////////////////////////////////////////////////////////////////////////////
   // Link status bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_buffer <= 8'h00;
         buffer_full <= 1'b0;
      end else begin
         if (ev_load) shift_buffer <= rx_shift;
         else if (wr && paddr == `I2S_OFS_BUF && !shifting) shift_buffer <= pwdata[7:0];
         if (ev_load || ev_rdreq) buffer_full <= 1'b1;
         else if (fall8 && state == st_tx) buffer_full <= 1'b0;
         else if (wr && paddr == `I2S_OFS_BUF && !shifting) buffer_full <= 1'b1;
         else if (rd && paddr == `I2S_OFS_BUF && state != st_tx) buffer_full <= 1'b0;
         else if (!port_enable) buffer_full <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_bit <= 1'b0;
         start_bit <= 1'b0;
      end else if (!port_enable) begin
         stop_bit <= 1'b0;
         start_bit <= 1'b0;
      end else if (start_det) begin
         start_bit <= 1'b1;
         stop_bit <= 1'b0;
      end else if (stop_det) begin
         stop_bit <= 1'b1;
         start_bit <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_not_address <= 1'b0;
         read_not_write <= 1'b0;
         address_update_needed <= 1'b0;
      end else begin
         if (ev_dna) data_not_address <= 1'b1;
         else if (ev_ada) data_not_address <= 1'b0;
         if (ev_ada) read_not_write <= rx_shift[0];
         if (ev_upd) address_update_needed <= 1'b1;
         else if ((wr && paddr == `I2S_OFS_ADDR && !mask_sel) || !ten) address_update_needed <= 1'b0;
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_hold_after_low: assert property ($fell(scl_oe_n) |-> !$past(scl_s)) else $error("SCL pulled before low");
   a_hold_until_release: assert property (scl_hold && !clock_release && slave_on && !stop_det |=> scl_hold)
      else $error("SCL let go early");
   a_write_collision_set: assert property (wr && paddr == `I2S_OFS_BUF && shifting |=> write_collision)
      else $error("Collision missed");
   a_ovf_set: assert property (fall8 && state == st_rx && buffer_full |=> receive_overflow ##0 !ack_drive)
      else $error("Overflow missed");
   a_pins_off: assert property (!port_enable |-> scl_oe_n && sda_oe_n) else $error("Pins driven while off");
   a_mask_route: assert property (wr && paddr == `I2S_OFS_ADDR && mask_sel |=> $stable(own_address))
      else $error("Own address hit in mask mode");
   a_stop_flag: assert property (stop_det |=> stop_bit && !start_bit) else $error("Stop flag wrong");
   a_start_flag: assert property (start_det |=> start_bit && !stop_bit) else $error("Start flag wrong");
   a_tx_full_clear: assert property (fall8 && state == st_tx && !ev_load |=> !buffer_full ##1 !buffer_full [*1])
      else $error("Buffer full not cleared");
   a_read_req: assert property (ev_rdreq |=> buffer_full && !clock_release && state == st_tx)
      else $error("Read request wrong");
   c_start: cover property (start_det);
   c_read_req: cover property (ev_rdreq);
   c_overflow: cover property (ev_ov);
   c_stretch: cover property (scl_hold ##1 !scl_hold);
endmodule : i2s_slave
`default_nettype wire

/* File: tb/i2s_master_bfm.sv */
// I2C bus master model for the slave port bench
// Assumes open-drain lines with pull-ups resolved by the bench
`timescale 1ns/100ps
`default_nettype none
module i2s_master_bfm #(parameter int HALF = 200) (
   // Resolved bus levels
   input wire logic scl,
   input wire logic sda,
   // Master drive, high means released
   output logic scl_o,
   output logic sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic clk_bit(input logic b, output logic r);
      sda_o = b;
      #(HALF/2);
      scl_o = 1'b1;
      while (scl !== 1'b1) #50;
      #(HALF/2);
      r = sda;
      #(HALF/2);
      scl_o = 1'b0;
      #(HALF/2);
   endtask : clk_bit
   task automatic start_c();
      sda_o = 1'b1;
      #(HALF/2);
      scl_o = 1'b1;
      #HALF;
      sda_o = 1'b0;
      #HALF;
      scl_o = 1'b0;
      #(HALF/2);
   endtask : start_c
   task automatic stop_c();
      sda_o = 1'b0;
      #(HALF/2);
      scl_o = 1'b1;
      #HALF;
      sda_o = 1'b1;
      #HALF;
   endtask : stop_c
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic acked);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], b);
         r[i] = b;
      end
      clk_bit(ack_in, b);
      acked = ~b;
   endtask : xfer
endmodule : i2s_master_bfm
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench of the I2C slave port
// Assumes the port register map of i2s_defines.svh and a 20 MHz pclk
`timescale 1ns/100ps
`default_nettype none
`include "i2s_defines.svh"
module tb_top;
   typedef struct {logic [7:0] a; logic [31:0] v; logic [31:0] m; logic e;} i2s_note_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ak;
   logic [7:0] paddr, rb, txd, rxd;
   logic [31:0] pwdata, prdata;
   logic scl_out, scl_oe_n, sda_out, sda_oe_n, port_owns_pins, slew_limit_en, irq, wake_req;
   logic m_scl, m_sda, scl_w, sda_w;
   logic [3:0] modes [5] = '{4'h6, 4'h7, 4'he, 4'hf, 4'hb};
   int err_total, checks, seed;
   i2s_note_t notes[$];
   i2s_note_t nt;
   assign scl_w = m_scl & (scl_oe_n | scl_out);
   assign sda_w = m_sda & (sda_oe_n | sda_out);
   i2s_slave i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .port_owns_pins(port_owns_pins), .slew_limit_en(slew_limit_en),
      .irq(irq), .wake_req(wake_req));
   i2s_master_bfm i_bfm (.scl(scl_w), .sda(sda_w), .scl_o(m_scl), .sda_o(m_sda));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input logic e = 1'b0);
      notes.push_back('{a, v, m, e});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic tdone(input string nm);
      repeat (4) @(posedge pclk);
      $display("test %s done", nm);
   endtask : tdone
   task automatic end_sim();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         nt = notes.pop_front();
         chk($sformatf("reg %h", nt.a), prdata & nt.m, nt.v & nt.m);
         chk("pslverr", 32'(pslverr), 32'(nt.e));
      end
   end
   initial begin
      #2000000;
      err_total++;
      end_sim();
   end
   initial begin
      seed = 32'h874c;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk("owns", 32'(port_owns_pins), 32'h0);
      chk("slew", 32'(slew_limit_en), 32'h1);
      rd(`I2S_OFS_CTRL, `I2S_CTRL_RST, 32'hffffffff);
      rd(`I2S_OFS_STAT, `I2S_STAT_RST, 32'hffffffff);
      rd(`I2S_OFS_ADDR, `I2S_ADDR_RST, 32'hff);
      rd(8'h14, 32'h0, 32'hffffffff, 1'b1);
      wr(`I2S_OFS_CTRL, 32'h29);
      rd(`I2S_OFS_ADDR, `I2S_MASK_RST, 32'hff);
      wr(`I2S_OFS_ADDR, 32'hf0);
      rd(`I2S_OFS_ADDR, 32'hf0, 32'hff);
      wr(`I2S_OFS_CTRL, 32'h36);
      rd(`I2S_OFS_ADDR, 32'h0, 32'hff);
      wr(`I2S_OFS_ADDR, 32'ha4);
      wr(`I2S_OFS_STAT, 32'h80);
      wr(`I2S_OFS_IRQ, 32'h2);
      @(negedge pclk);
      chk("owns", 32'(port_owns_pins), 32'h1);
      chk("slew", 32'(slew_limit_en), 32'h0);
      tdone("registers");
      i_bfm.start_c();
      i_bfm.xfer(8'haa, 1'b1, rb, ak);
      chk("addr ack", 32'(ak), 32'h1);
      rd(`I2S_OFS_STAT, 32'h09, 32'h3d);
      chk("irq", 32'(irq), 32'h1);
      chk("wake", 32'(wake_req), 32'h1);
      rd(`I2S_OFS_BUF, 32'haa, 32'hff);
      rd(`I2S_OFS_STAT, 32'h0, 32'h1);
      wr(`I2S_OFS_IRQ, 32'h2);
      @(negedge pclk);
      chk("irq", 32'(irq), 32'h0);
      rxd = 8'($random(seed));
      i_bfm.xfer(rxd, 1'b1, rb, ak);
      chk("data ack", 32'(ak), 32'h1);
      i_bfm.xfer(~rxd, 1'b1, rb, ak);
      chk("ovf ack", 32'(ak), 32'h0);
      i_bfm.stop_c();
      rd(`I2S_OFS_STAT, 32'h31, 32'h39);
      rd(`I2S_OFS_CTRL, 32'h40, 32'h40);
      rd(`I2S_OFS_BUF, 32'(rxd), 32'hff);
      wr(`I2S_OFS_CTRL, 32'h36);
      tdone("write");
      i_bfm.start_c();
      i_bfm.xfer(8'h24, 1'b1, rb, ak);
      chk("miss ack", 32'(ak), 32'h0);
      i_bfm.stop_c();
      tdone("mismatch");
      txd = 8'($random(seed));
      i_bfm.start_c();
      i_bfm.xfer(8'ha5, 1'b1, rb, ak);
      chk("rd ack", 32'(ak), 32'h1);
      wr(`I2S_OFS_IRQ, 32'h2);
      fork
         i_bfm.xfer(8'hff, 1'b1, rb, ak);
         begin
            repeat (20) @(posedge pclk);
            @(negedge pclk);
            chk("scl hold", 32'(scl_oe_n), 32'h0);
            rd(`I2S_OFS_STAT, 32'h05, 32'h25);
            rd(`I2S_OFS_CTRL, 32'h0, 32'h10);
            wr(`I2S_OFS_BUF, 32'(txd));
            wr(`I2S_OFS_CTRL, 32'h36);
            repeat (20) @(posedge pclk);
            wr(`I2S_OFS_BUF, 32'h0);
         end
      join
      chk("tx data", 32'(rb), 32'(txd));
      rd(`I2S_OFS_CTRL, 32'h80, 32'h80);
      rd(`I2S_OFS_STAT, 32'h0, 32'h1);
      chk("irq", 32'(irq), 32'h1);
      i_bfm.stop_c();
      tdone("read");
      wr(`I2S_OFS_CTRL, 32'h37);
      wr(`I2S_OFS_ADDR, 32'hf2);
      i_bfm.start_c();
      i_bfm.xfer(8'hf2, 1'b1, rb, ak);
      chk("hdr ack", 32'(ak), 32'h1);
      rd(`I2S_OFS_STAT, 32'h03, 32'h23);
      chk("ua hold", 32'(scl_oe_n), 32'h0);
      rd(`I2S_OFS_BUF, 32'hf2, 32'hff);
      wr(`I2S_OFS_ADDR, 32'h5a);
      i_bfm.xfer(8'h5a, 1'b1, rb, ak);
      chk("low ack", 32'(ak), 32'h1);
      rd(`I2S_OFS_STAT, 32'h03, 32'h23);
      rd(`I2S_OFS_BUF, 32'h5a, 32'hff);
      wr(`I2S_OFS_ADDR, 32'hf2);
      rd(`I2S_OFS_STAT, 32'h0, 32'h2);
      i_bfm.xfer(rxd, 1'b1, rb, ak);
      chk("ten data ack", 32'(ak), 32'h1);
      i_bfm.stop_c();
      tdone("ten bit");
      for (int i = 0; i < 5; i++) begin
         wr(`I2S_OFS_CTRL, 32'h20 | 32'(modes[i]));
         rd(`I2S_OFS_CTRL, 32'h20 | 32'(modes[i]), 32'hff);
      end
      for (int i = 2; i < 5; i += 2) begin
         wr(`I2S_OFS_CTRL, 32'h20 | 32'(modes[i]));
         wr(`I2S_OFS_IRQ, 32'h2);
         i_bfm.start_c();
         i_bfm.stop_c();
         repeat (6) @(posedge pclk);
         chk("irq", 32'(irq), 32'h1);
      end
      wr(`I2S_OFS_CTRL, 32'h0);
      @(negedge pclk);
      chk("owns", 32'(port_owns_pins), 32'h0);
      rd(`I2S_OFS_STAT, 32'h0, 32'h18);
      tdone("modes");
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
